// ==== rtl/isp_consts.vh ====
// Functional notes
// - device changes its serial output after each falling serial clock edge.
// - input sampled on rising edges; host keeps clock <=2 MHz, <=1 MHz burst (bench host clocks 6.25 MHz in both).
// - data-ready asserts about 600 us after each active sync edge.
// - fourth digital pin is either general-purpose I/O or sync clock input.
// - mode 3 transfers, most significant bit first, 16-bit words.
// - single read: request word, register contents return in next word.
// - command 0x3e00 starts burst; all output registers shift out in order.
// - without sync clock, first digital pin pulses high when each sample cycle ends.
`ifndef ISP_CONSTS_VH
`define ISP_CONSTS_VH
`define ISP_CLK_MHZ 100
`define ISP_SYNC_DELAY_US 600
`define ISP_SYNC_DELAY_CYC (`ISP_SYNC_DELAY_US * `ISP_CLK_MHZ)
`define ISP_READY_PULSE_CYC 16'h0064
`define ISP_BURST_CMD 16'h3e00
`define ISP_ADDR_FIRST 6'h02
`define ISP_ADDR_LAST 6'h1c
`define ISP_WORD_BITS 16
`endif

// ==== rtl/isp_serial_port.v ====
`timescale 1ns/1ps
`include "isp_consts.vh"

// ==========================================================
// fifo
module isp_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_sys, // system clock
   input wire sys_rst, // sync reset
   input wire clkEn, // clock enable
   input wire [WIDTH-1:0] inData, // write data
   input wire inValid, // write valid
   output wire inReady, // not full
   output wire [WIDTH-1:0] outData, // read data
   output wire outValid, // not empty
   input wire outReady // reader takes word
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] count;
   wire doWr;
   wire doRd;
   assign inReady = (count != DEPTH);
   assign outValid = (count != 0);
   assign outData = mem[rdPtr];
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (clkEn) begin
         if (doWr) begin
            mem[wrPtr] <= inData;
            wrPtr <= wrPtr + 1'b1;
         end
         if (doRd)
            rdPtr <= rdPtr + 1'b1;
         if (doWr && !doRd)
            count <= count + 1'b1;
         else if (doRd && !doWr)
            count <= count - 1'b1;
      end
   end
endmodule // isp_fifo

// ==========================================================
// serial slave port with sample sync
module isp_serial_port #(
   parameter SYNC_DELAY = `ISP_SYNC_DELAY_CYC,
   parameter FIFO_DEPTH = 16
) (
   input wire clk_sys, // system clock 100 MHz
   input wire sys_rst, // sync reset, high
   input wire clkEn, // freezes state when low
   input wire chipSelN, // chip select, low active
   input wire serClk, // serial clock from host
   input wire serIn, // host to device data
   output reg serOut, // device to host data
   output wire serOutEn, // high while serOut driven
   input wire syncSel, // 1: fourth pin is sync clock
   input wire syncClockPinIn, // fourth pin level
   output wire syncClockPinOut, // fourth pin drive value
   output wire syncClockPinOe, // fourth pin enable
   input wire gpioOut, // gpio value for fourth pin
   input wire gpioOe, // gpio enable for fourth pin
   output wire gpioIn, // fourth pin as seen by gpio
   output reg dataReadyPin, // first digital pin
   input wire [15:0] smpData, // sensor word for sample bank
   input wire smpValid, // sample word valid
   output wire smpReady, // fifo can take word
   input wire smpDone, // internal sample cycle end
   output wire [5:0] regAddr, // register read address
   input wire [15:0] regData // register contents
);
   // ==========================================================
   // synchronisers
   reg [1:0] csS, ckS, dS, syS;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         csS <= 2'h3;
         ckS <= 2'h3;
         dS <= 2'h0;
         syS <= 2'h0;
      end else if (clkEn) begin
         csS <= {csS[0], chipSelN};
         ckS <= {ckS[0], serClk};
         dS <= {dS[0], serIn};
         syS <= {syS[0], syncClockPinIn};
      end
   end
   reg ckD, syD;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ckD <= 1'b1;
         syD <= 1'b0;
      end else if (clkEn) begin
         ckD <= ckS[1];
         syD <= syS[1];
      end
   end
   wire sel = !csS[1];
   wire rise = sel && ckS[1] && !ckD;
   wire fall = sel && !ckS[1] && ckD;

   // ==========================================================
   // fourth pin mux
   // gpio or sync input
   assign syncClockPinOe = syncSel ? 1'b0 : gpioOe;
   assign syncClockPinOut = gpioOut;
   assign gpioIn = syS[1];

   // ==========================================================
   // shift engine
   reg [15:0] rxSh, txSh;
   reg [3:0] bitCnt;
   reg burst;
   reg [5:0] addrQ;
   reg [5:0] burstAddr;
   reg firstFall;
   assign serOutEn = sel;
   assign regAddr = burst ? burstAddr : addrQ;
   wire [15:0] rxWord = {rxSh[14:0], dS[1]};
   wire wordEnd = rise && (bitCnt == 4'hf);
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         rxSh <= 16'h0000;
         txSh <= 16'h0000;
         bitCnt <= 4'h0;
         burst <= 1'b0;
         addrQ <= 6'h00;
         burstAddr <= `ISP_ADDR_FIRST;
         serOut <= 1'b0;
         firstFall <= 1'b1;
      end else if (clkEn) begin
         if (!sel) begin
            bitCnt <= 4'h0;
            firstFall <= 1'b1;
            if (!burst)
               txSh <= regData;
         end else begin
            if (rise) begin
               rxSh <= rxWord;
               bitCnt <= bitCnt + 4'h1;
            end
            if (fall) begin
               serOut <= txSh[15];
               txSh <= {txSh[14:0], 1'b0};
               firstFall <= 1'b0;
            end
            if (wordEnd) begin
               // re-arm reload so a word under a held select is not empty
               firstFall <= 1'b1;
               if (!burst && rxWord == `ISP_BURST_CMD) begin
                  burst <= 1'b1;
                  burstAddr <= `ISP_ADDR_FIRST;
               end else if (burst) begin
                  if (burstAddr == `ISP_ADDR_LAST)
                     burst <= 1'b0;
                  else
                     burstAddr <= burstAddr + 6'h02;
               end else begin
                  addrQ <= rxWord[13:8];
               end
            end
            // reload for next word once chip select stays low (burst)
            if (bitCnt == 4'h0 && firstFall && !fall)
               txSh <= regData;
         end
      end
   end

   // ==========================================================
   // sample fifo, drained by sample-cycle end
   wire [15:0] fifoData;
   wire fifoValid;
   isp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(4)) uFifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clkEn(clkEn),
      .inData(smpData),
      .inValid(smpValid),
      .inReady(smpReady),
      .outData(fifoData),
      .outValid(fifoValid),
      .outReady(smpDone)
   );

   // ==========================================================
   // sync delay and data ready
   reg [31:0] dlyCnt;
   reg dlyRun;
   reg [15:0] pulseCnt;
   reg [15:0] lastSample;
   wire syncEdge = syncSel && syS[1] && !syD;
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         dlyCnt <= 32'h0;
         dlyRun <= 1'b0;
         pulseCnt <= 16'h0000;
         dataReadyPin <= 1'b0;
         lastSample <= 16'h0000;
      end else if (clkEn) begin
         if (smpDone && fifoValid)
            lastSample <= fifoData;
         if (syncEdge) begin
            dlyRun <= 1'b1;
            dlyCnt <= 32'h0;
         end else if (dlyRun) begin
            dlyCnt <= dlyCnt + 32'h1;
         end
         if ((dlyRun && dlyCnt == SYNC_DELAY - 1 && !syncEdge) ||
               (!syncSel && smpDone)) begin
            if (dlyRun)
               dlyRun <= 1'b0;
            pulseCnt <= `ISP_READY_PULSE_CYC;
            dataReadyPin <= 1'b1;
         end else if (pulseCnt != 16'h0000) begin
            pulseCnt <= pulseCnt - 16'h0001;
            dataReadyPin <= (pulseCnt != 16'h0001);
         end
      end
   end
endmodule // isp_serial_port

// ==== test/isp_host_model.sv ====
`timescale 1ns/1ps
// ====
// serial bus master
module isp_host (
   output logic chipSelN, // select
   output logic serClk, // sclk
   output logic serIn, // din
   input wire serOut // dout
);
   initial begin
      chipSelN = 1'b1;
      serClk = 1'b1;
      serIn = 1'b0;
   end
   task automatic xfer(input logic [15:0] tx, input logic keep,
         input int gap, output logic [15:0] rx);
      chipSelN = 1'b0;
      #53;
      for (int i = 15; i >= 0; i--) begin
         serClk = 1'b0;
         serIn = tx[i];
         #80;
         serClk = 1'b1;
         rx[i] = serOut;
         #80;
      end
      // line left stale would hide a late sample
      serIn = ~serIn;
      // keep high holds select low into the next word
      chipSelN = !keep;
      #(gap);
   endtask
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         serClk = 1'b0;
         #80;
         serClk = 1'b1;
         #80;
      end
   endtask
endmodule // isp_host

// ==== test/isp_serial_port_sva.sv ====
`timescale 1ns/1ps
// ====
// port checker
module isp_chk #(parameter SYNC_DELAY = 50) (
   input wire clk_sys, // clock
   input wire sys_rst, // reset
   input wire chipSelN, // select
   input wire serClk, // sclk
   input wire serOut, // dout
   input wire serOutEn, // dout on
   input wire syncSel, // sync mode
   input wire syncClockPinIn, // pin
   input wire syncClockPinOe, // pin oe
   input wire gpioOe, // gpio oe
   input wire gpioIn, // gpio in
   input wire dataReadyPin, // ready
   input wire smpDone, // cycle end
   input wire smpReady // fifo room
);
   localparam int DLO = SYNC_DELAY;
   localparam int DHI = SYNC_DELAY + 8;
   reg [7:0] hiCnt;
   always @(posedge clk_sys) begin
      hiCnt <= (sys_rst || !dataReadyPin) ? 8'h00 : hiCnt + 8'h01;
   end
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   oe_idle_a: assert property (chipSelN[*3] |-> !serOutEn)
      else $error("dout driven while deselected");
   oe_frame_a: assert property (!chipSelN[*4] |-> serOutEn)
      else $error("dout idle in frame");
   pin_oe_a: assert property (syncClockPinOe == (gpioOe && !syncSel))
      else $error("pin drive wrong for mode");
   gpio_in_a: assert property ($stable(syncClockPinIn)[*4] |->
      gpioIn == syncClockPinIn) else $error("gpio level lost");
   out_hold_a: assert property ((serClk && !chipSelN)[*6] |->
      $stable(serOut)) else $error("dout moved while sclk high");
   ready_len_a: assert property ($fell(dataReadyPin) |-> hiCnt == 8'h64)
      else $error("ready pulse width wrong");
   sync_ready_a: assert property (syncSel && $rose(syncClockPinIn) |->
      ##[DLO:DHI] dataReadyPin) else $error("no ready after sync");
   smp_ready_a: assert property (!syncSel && smpDone |->
      ##[1:4] dataReadyPin) else $error("no ready after sample");
   cover property ($rose(dataReadyPin));
   cover property (!smpReady);
   cover property ($rose(chipSelN));
endmodule // isp_chk

bind isp_serial_port isp_chk #(.SYNC_DELAY(SYNC_DELAY)) chk_u (.*);

// ==== test/imu_serial_port_sync_timing_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
// ====
// bench top
module imu_serial_port_sync_timing_tb;
   logic clk_sys, sys_rst = 1'b1, clkEn = 1'b1, syncSel = 1'b0;
   logic pinDrv = 1'b0, gpioOut = 1'b0, gpioOe = 1'b0;
   logic smpValid = 1'b0, smpDone = 1'b0;
   logic [15:0] smpData = 16'h0000, rx;
   logic [5:0] a, b;
   wire chipSelN, serClk, serIn, serOut, serOutEn, syncClockPinIn;
   wire syncClockPinOut, syncClockPinOe, gpioIn, dataReadyPin, smpReady;
   wire [5:0] regAddr;
   wire [15:0] regData;
   int seed = 32'hd2d8;
   int n_errors = 0;
   int compares = 0;
   int k = 0;
   // register bank seen by the port, and the pin resolved from both drivers
   assign regData = {regAddr, ~regAddr, 4'h9};
   assign syncClockPinIn = syncClockPinOe ? syncClockPinOut : pinDrv;
   // a released data line shows the inverse so a stray sample shows up
   wire hostMiso = serOutEn ? serOut : ~serOut;
   isp_serial_port #(.SYNC_DELAY(50)) dut_u (.*);
   isp_host host_u (.chipSelN(chipSelN), .serClk(serClk), .serIn(serIn),
      .serOut(hostMiso));
   function automatic logic [15:0] expv(input logic [5:0] ad);
      return {ad, ~ad, 4'h9};
   endfunction
   task automatic finish_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      a = {1'b0, 5'($random(seed))};
      #3;
      host_u.xfer({2'b00, a, 8'h00}, 1'b0, 40000, rx);
      for (k = 0; k < 4; k++) begin
         b = {1'b0, 5'($random(seed))};
         @(posedge clk_sys) {gpioOut, gpioOe} <= 2'($random(seed));
         #3;
         host_u.xfer({2'b00, b, 8'h00}, 1'b0, 40000, rx);
         `CHK(rx, expv(a))
         `CHK(gpioIn, gpioOe ? gpioOut : pinDrv)
         a = b;
      end
      host_u.stray(8);
      host_u.xfer(16'h0000, 1'b0, 40000, rx);
      `CHK(rx, expv(a))
      host_u.xfer(16'h3e00, 1'b1, 160, rx);
      for (k = 0; k < 14; k++) begin
         host_u.xfer(16'h0000, k < 13, (k < 13) ? 160 : 40000, rx);
         `CHK(rx, expv(6'h02 + 6'(2 * k)))
      end
      k = 0;
      @(posedge clk_sys) smpValid <= 1'b1;
      repeat (20) begin
         @(negedge clk_sys) k += int'(smpReady);
         @(posedge clk_sys) smpData <= 16'($random(seed));
      end
      smpValid <= 1'b0;
      `CHK(k, 16)
      repeat (16) begin
         @(posedge clk_sys) smpDone <= 1'b1;
         @(posedge clk_sys) smpDone <= 1'b0;
         repeat (4) @(negedge clk_sys);
         `CHK(dataReadyPin, 1'b1)
         repeat (110) @(posedge clk_sys);
      end
      `CHK(smpReady, 1'b1)
      @(posedge clk_sys) syncSel <= 1'b1;
      repeat (200) @(posedge clk_sys);
      // sync high phase held well past data ready
      pinDrv <= 1'b1;
      k = 0;
      while (dataReadyPin !== 1'b1 && k < 200) begin
         @(negedge clk_sys);
         k++;
      end
      `CHK(k >= 50 && k <= 58, 1'b1)
      repeat (500) @(posedge clk_sys);
      pinDrv <= 1'b0;
      finish_test();
   end
endmodule // imu_serial_port_sync_timing_tb
